/* design/shutdown_feature_defines.vh */
// Constants for the shutdown sequencer and the feature value store.
// Included by the design files; holds definitions only.
`ifndef SHUTDOWN_FEATURE_DEFINES_VH
`define SHUTDOWN_FEATURE_DEFINES_VH

// Register offsets (word addresses on the plain register port)
`define REG_CTRL_CFG 4'h0
`define REG_CTRL_STATUS 4'h1
`define REG_FEAT_CMD 4'h2
`define REG_FEAT_DATA 4'h3
`define REG_FEAT_RESULT 4'h4
`define REG_SQ_DELETE 4'h5
`define REG_SQ_ABORTED 4'h6

// Control register fields
`define CFG_EN_BIT 0
`define CFG_SHN_LSB 14
`define CFG_SAVE_SUPPORT_BIT 4
// Status register fields
`define STS_RDY_BIT 0
`define STS_SHST_LSB 2

// Shutdown notify and shutdown state encodings
`define SHN_NONE 2'h0
`define SHN_NORMAL 2'h1
`define SHN_ABRUPT 2'h2
`define SHST_NORMAL 2'h0
`define SHST_BUSY 2'h1
`define SHST_DONE 2'h2

// Feature command fields: opcode, select, save flag, feature id, namespace
`define FC_OP_LSB 30
`define FC_SEL_LSB 27
`define FC_SAVE_BIT 26
`define FC_FID_LSB 24
`define FC_NSID_LSB 0
`define NSID_W 24
`define NSID_ALL_ZERO 24'h000000
`define NSID_ALL_ONES 24'hFFFFFF
`define NUM_NS 4
`define OP_GET 2'h1
`define OP_SET 2'h2
`define SEL_CURRENT 3'h0
`define SEL_DEFAULT 3'h1
`define SEL_SAVED 3'h2
`define NUM_FEAT 4

// Completion status codes
`define ST_OK 8'h00
`define ST_INVALID_FIELD 8'h02
`define ST_NOT_NS_SPECIFIC 8'h0F

// Default feature values, fixed in hardware
`define FEAT_DEFAULTS 64'h0000_0007_0000_0100
// Which features are namespace specific (bit per feature)
`define FEAT_NS_SPECIFIC 4'h2
// Which features exist
`define FEAT_SUPPORTED 4'h7

// Timing
// Shutdown takes 2000 ns, that is 40 cycles of the 50 ns clock
`define SHUTDOWN_CYC 8'h28
`define RESET_CYC 4'h8

`endif

/* design/feature_store.v */
// Feature value store: default, saved and current value of each feature,
// saved values kept per namespace as well as controller-wide.
// Assumes commands come one cycle at a time from the shutdown_ctrl top.
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_feature_defines.vh"
module feature_store (
  input wire mclk,
  input wire rst_n,
  input wire reload,
  input wire save_support,
  input wire cmd_valid,
  input wire [31:0] cmd_word,
  input wire [15:0] cmd_data,
  output reg [15:0] result_r,
  output reg [7:0] status_r,
  output reg done_r
);
  localparam [63:0] DEFAULTS = `FEAT_DEFAULTS;
  reg [15:0] cur_r [0:`NUM_FEAT-1];
  reg [15:0] sav_r [0:`NUM_FEAT*(`NUM_NS+1)-1];
  wire [1:0] op = cmd_word[`FC_OP_LSB+1:`FC_OP_LSB];
  wire [2:0] sel = cmd_word[`FC_SEL_LSB+2:`FC_SEL_LSB];
  wire save = cmd_word[`FC_SAVE_BIT];
  wire [1:0] fid = cmd_word[`FC_FID_LSB+1:`FC_FID_LSB];
  wire [`NSID_W-1:0] nsid = cmd_word[`FC_NSID_LSB+`NSID_W-1:`FC_NSID_LSB];
  wire [3:0] supported = `FEAT_SUPPORTED;
  wire [3:0] ns_spec = `FEAT_NS_SPECIFIC;
  // Namespace 0h and all-ones both mean controller-wide
  wire wide = (nsid == `NSID_ALL_ZERO) || (nsid == `NSID_ALL_ONES);
  wire ns_ok = !wide && (nsid <= `NUM_NS);
  // Per-namespace slots only when saving is supported
  wire [2:0] slot = (ns_ok && save_support) ? nsid[2:0] : 3'h0;
  // Five saved slots per feature: controller-wide first, then one per namespace
  wire [4:0] sidx = {1'b0, fid, 2'h0} + {3'h0, fid} + {2'h0, slot};
  wire [15:0] dflt = DEFAULTS[{fid, 4'h0} +: 16];
  integer i;

  // Command decode, one command per cycle
  always @(posedge mclk) begin
    if (!rst_n) begin
      result_r <= 16'h0000;
      status_r <= `ST_OK;
      done_r <= 1'b0;
    end else begin
      done_r <= cmd_valid;
      if (cmd_valid) begin
        result_r <= 16'h0000;
        if (!supported[fid] || (op != `OP_GET && op != `OP_SET)) begin
          status_r <= `ST_INVALID_FIELD;
        end else if (op == `OP_SET && ns_ok && !ns_spec[fid] && !save_support) begin
          status_r <= `ST_NOT_NS_SPECIFIC;
        end else begin
          status_r <= `ST_OK;
          if (op == `OP_GET) begin
            // Get returns default, saved or current value
            case (sel)
              `SEL_DEFAULT: result_r <= dflt;
              `SEL_SAVED: result_r <= save_support ? sav_r[sidx] : dflt;
              default: result_r <= cur_r[fid];
            endcase
          end
        end
      end
    end
  end

  // Value arrays; defaults are never written by any command
  always @(posedge mclk) begin
    if (!rst_n || reload) begin
      // Power-on takes default; controller reset takes saved value, or default without save
      for (i = 0; i < `NUM_FEAT; i = i + 1) begin
        cur_r[i] <= (save_support && rst_n) ? sav_r[i*(`NUM_NS+1)] : DEFAULTS[i*16 +: 16];
      end
      if (!rst_n) begin
        for (i = 0; i < `NUM_FEAT*(`NUM_NS+1); i = i + 1) begin
          sav_r[i] <= DEFAULTS[(i/(`NUM_NS+1))*16 +: 16];
        end
      end
    end else if (cmd_valid && op == `OP_SET && supported[fid]
                 && !(ns_ok && !ns_spec[fid] && !save_support)) begin
      cur_r[fid] <= cmd_data; // Current value follows set
      if (save && save_support) begin
        sav_r[sidx] <= cmd_data;
      end
    end
  end
endmodule
`default_nettype wire

/* design/shutdown_ctrl.v */
// Top: controller enable/ready, shutdown sequencing and queue delete abort,
// with the feature store behind a plain register port.
// Assumes a single clock mclk and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_feature_defines.vh"
module shutdown_ctrl (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  output reg [7:0] sq_outstanding_r,
  output wire cmd_exec_allowed,
  output wire power_off_safe
);
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_RUN = 2'h1;
  localparam [1:0] ST_SHUT = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg en_r;
  reg save_support_r;
  reg [1:0] shn_r;
  reg [1:0] shst_r;
  reg rdy_r;
  reg safe_r;
  reg [3:0] rst_cnt_r;
  reg [7:0] sd_cnt_r;
  reg [31:0] feat_cmd_r;
  reg [15:0] feat_data_r;
  reg feat_go_r;
  reg [7:0] aborted_r;
  wire [15:0] feat_result;
  wire [7:0] feat_status;
  wire feat_done;
  wire wr_cfg = reg_wr && (reg_addr == `REG_CTRL_CFG);
  wire new_en = reg_wdata[`CFG_EN_BIT];
  wire [1:0] new_shn = reg_wdata[`CFG_SHN_LSB+1:`CFG_SHN_LSB];
  // Enable falling from 1 to 0 is a controller reset
  wire ctrl_reset = wr_cfg && en_r && !new_en;
  wire en_rise = wr_cfg && !en_r && new_en;
  wire shn_req = wr_cfg && (new_shn == `SHN_NORMAL || new_shn == `SHN_ABRUPT)
                 && (state_r == ST_RUN);

  // Command execution only while running and ready
  assign cmd_exec_allowed = (state_r == ST_RUN) && rdy_r;
  assign power_off_safe = safe_r;

  // Lifecycle state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (en_r && rst_cnt_r == 4'h0) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ctrl_reset) begin
          state_nxt = ST_OFF;
        end else if (shn_req) begin
          state_nxt = ST_SHUT;
        end
      end
      ST_SHUT: begin
        if (ctrl_reset) begin
          state_nxt = ST_OFF;
        end else if (sd_cnt_r == 8'h00) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        // Only a controller reset leaves the shut-down state
        if (ctrl_reset) begin
          state_nxt = ST_OFF;
        end
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // Control and status registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      en_r <= 1'b0;
      save_support_r <= 1'b1;
      shn_r <= `SHN_NONE;
      shst_r <= `SHST_NORMAL;
      rdy_r <= 1'b0;
      safe_r <= 1'b0;
      rst_cnt_r <= 4'h0;
      sd_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (wr_cfg) begin
        en_r <= new_en;
        shn_r <= new_shn;
        save_support_r <= reg_wdata[`CFG_SAVE_SUPPORT_BIT];
      end
      // Controller reset takes a few cycles before ready may rise
      if (ctrl_reset) begin
        rst_cnt_r <= `RESET_CYC;
      end else if (rst_cnt_r != 4'h0) begin
        rst_cnt_r <= rst_cnt_r - 4'h1;
      end
      // Ready is 1 only while enabled and out of reset
      rdy_r <= (state_nxt != ST_OFF);
      if (shn_req) begin
        sd_cnt_r <= `SHUTDOWN_CYC;
        shst_r <= `SHST_BUSY;
      end else if (state_r == ST_SHUT && sd_cnt_r != 8'h00) begin
        sd_cnt_r <= sd_cnt_r - 8'h01;
      end
      if (state_r == ST_SHUT && state_nxt == ST_DONE) begin
        shst_r <= `SHST_DONE;
        safe_r <= 1'b1;
      end
      // Completion stays visible while power-off is still safe
      if ((ctrl_reset && !safe_r) || en_rise) begin
        shst_r <= `SHST_NORMAL;
      end
      // Safe to power off holds across enable clear until enable rises
      if (en_rise) begin
        safe_r <= 1'b0;
      end
    end
  end

  // Feature command launch; a write to the command register starts it only while command execution is allowed
  always @(posedge mclk) begin
    if (!rst_n) begin
      feat_cmd_r <= 32'h00000000;
      feat_data_r <= 16'h0000;
      feat_go_r <= 1'b0;
    end else begin
      feat_go_r <= reg_wr && (reg_addr == `REG_FEAT_CMD) && cmd_exec_allowed;
      if (reg_wr && reg_addr == `REG_FEAT_CMD) begin
        feat_cmd_r <= reg_wdata;
      end
      if (reg_wr && reg_addr == `REG_FEAT_DATA) begin
        feat_data_r <= reg_wdata[15:0];
      end
    end
  end

  // Outstanding I/O count on the submission queue and abort on delete
  always @(posedge mclk) begin
    if (!rst_n) begin
      sq_outstanding_r <= 8'h00;
      aborted_r <= 8'h00;
    end else if (reg_wr && reg_addr == `REG_SQ_DELETE && cmd_exec_allowed) begin
      if (reg_wdata[31]) begin
        // Delete succeeds and aborts everything still queued
        aborted_r <= sq_outstanding_r;
        sq_outstanding_r <= 8'h00;
      end else begin
        sq_outstanding_r <= reg_wdata[7:0];
      end
    end
  end

  feature_store u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .reload(ctrl_reset),
    .save_support(save_support_r),
    .cmd_valid(feat_go_r),
    .cmd_word(feat_cmd_r),
    .cmd_data(feat_data_r),
    .result_r(feat_result),
    .status_r(feat_status),
    .done_r(feat_done)
  );

  // Read data one cycle after the read strobe; unmapped reads give zero
  always @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `REG_CTRL_CFG: reg_rdata_r <= {16'h0000, shn_r, 9'h000,
                                       save_support_r, 3'h0, en_r};
        `REG_CTRL_STATUS: reg_rdata_r <= {28'h0000000, shst_r, 1'b0, rdy_r};
        `REG_FEAT_CMD: reg_rdata_r <= feat_cmd_r;
        `REG_FEAT_DATA: reg_rdata_r <= {16'h0000, feat_data_r};
        `REG_FEAT_RESULT: reg_rdata_r <= {feat_done, 7'h00, feat_status, feat_result};
        `REG_SQ_ABORTED: reg_rdata_r <= {24'h000000, aborted_r};
        default: reg_rdata_r <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_r <= 32'h00000000;
    end
  end
endmodule
`default_nettype wire

/* sim/shutdown_ctrl_chk.sv */
// Checker for shutdown_ctrl: shutdown sequencing, queue abort and ready.
// Assumes it is bound to shutdown_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_feature_defines.vh"
module shutdown_ctrl_chk (
  input wire mclk,
  input wire rst_n,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_r,
  input wire [7:0] sq_outstanding_r,
  input wire cmd_exec_allowed,
  input wire power_off_safe
);
  // Decoded host requests; queue and shutdown writes only count while running
  wire cfg_wr = reg_wr && reg_addr == `REG_CTRL_CFG;
  wire en_up = cfg_wr && reg_wdata[0];
  wire sq_wr = reg_wr && reg_addr == `REG_SQ_DELETE && cmd_exec_allowed;
  wire shut_req = en_up && (reg_wdata[15:14] == `SHN_NORMAL || reg_wdata[15:14] == `SHN_ABRUPT)
                  && cmd_exec_allowed;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rst_ready_a: assert property ($rose(rst_n) |-> !cmd_exec_allowed)
    else $error("ready straight after reset");
  sq_abort_a: assert property (sq_wr && reg_wdata[31] |=> sq_outstanding_r == 8'h0)
    else $error("delete left commands outstanding");
  sq_count_a: assert property (sq_wr && !reg_wdata[31]
    |=> sq_outstanding_r == $past(reg_wdata[7:0]))
    else $error("outstanding count not loaded");
  shut_busy_a: assert property (shut_req |=> !power_off_safe [*8])
    else $error("shutdown finished too early");
  shut_done_a: assert property (shut_req |-> ##[30:50] power_off_safe)
    else $error("shutdown never completed");
  shst_read_a: assert property (power_off_safe && reg_rd && reg_addr == `REG_CTRL_STATUS
    |=> reg_rdata_r[3:2] == `SHST_DONE)
    else $error("status hides completion");
  exec_stop_a: assert property (power_off_safe |-> !cmd_exec_allowed)
    else $error("commands run after shutdown");
  en_clear_a: assert property (cfg_wr && !reg_wdata[0] && cmd_exec_allowed
    |-> ##2 !cmd_exec_allowed)
    else $error("ready kept through controller reset");
  safe_hold_a: assert property ($fell(power_off_safe) |-> $past(en_up, 1) || $past(en_up, 2))
    else $error("power-off safety lost without enable");
endmodule
bind shutdown_ctrl shutdown_ctrl_chk i_shutdown_ctrl_chk (.mclk(mclk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_r(reg_rdata_r), .sq_outstanding_r(sq_outstanding_r),
  .cmd_exec_allowed(cmd_exec_allowed), .power_off_safe(power_off_safe));
`default_nettype wire

/* sim/host_model.sv */
// Host software model: register bus master and the host shutdown steps.
// Assumes the plain register port of shutdown_ctrl; one request per wr or rd call.
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_feature_defines.vh"
module host_model (
  input wire logic mclk,
  input wire logic [31:0] reg_rdata_r,
  output logic [3:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Bus idle from time zero
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 38'h0;
  end
  // One bus cycle; idle data toggles so a stale word is never trusted
  task cyc(input logic w, input logic r, input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    {reg_wr, reg_rd, reg_addr} <= {w, r, a};
    reg_wdata <= w ? v : ~reg_wdata;
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    cyc(1'h1, 1'h0, a, v);
    cyc(1'h0, 1'h0, a, 32'h0);
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] v);
    cyc(1'h0, 1'h1, a, 32'h0);
    cyc(1'h0, 1'h0, a, 32'h0);
    v = reg_rdata_r;
  endtask
  task feat(input logic [1:0] op, input logic [2:0] sel, input logic [1:0] fid,
            input logic [23:0] ns, input logic [15:0] v, output logic [31:0] res);
    wr(`REG_FEAT_DATA, {16'h0, v});
    wr(`REG_FEAT_CMD, {op, sel, 1'h1, fid, ns});
    rd(`REG_FEAT_RESULT, res);
  endtask
  // Event requests outstanding; one completion is serviced and re-posted
  int events_out = 1;
  // Event completion: mask the page's events, fetch and parse the page,
  // then re-arm all but the persistent ones; feature 0 stands for the config
  task event_service(input logic [15:0] keep, output logic [31:0] page);
    logic [31:0] ack;
    events_out--;
    feat(`OP_SET, `SEL_CURRENT, 2'h0, 24'h0, 16'h0, ack);
    feat(`OP_GET, `SEL_CURRENT, 2'h0, 24'h0, 16'h0, page);
    feat(`OP_SET, `SEL_CURRENT, 2'h0, 24'h0, keep, ack);
    events_out++;
  endtask
  // Normal shutdown deletes the queue first; abrupt goes straight to notify
  task shut(input logic [1:0] kind);
    if (kind == `SHN_NORMAL) wr(`REG_SQ_DELETE, 32'h8000_0000);
    wr(`REG_CTRL_CFG, {16'h0, kind, 9'h0, 1'h1, 3'h0, 1'h1});
  endtask
  // Poll status until done; bounded since latency is reported as zero here
  task wait_done(output logic [31:0] v);
    int n;
    n = 0;
    v = 32'h0;
    while (v[3:2] !== `SHST_DONE && n < 100) begin
      rd(`REG_CTRL_STATUS, v);
      n++;
    end
  endtask
endmodule
`default_nettype wire

/* sim/shutdown_feature_values_test.sv */
// Self-checking bench for shutdown_ctrl driven through the host model.
// Assumes the defines header and a 50 ns clock; random data from xorshift.
`timescale 1ns/1ps
`default_nettype none
`include "shutdown_feature_defines.vh"
module shutdown_feature_values_test;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic reg_wr, reg_rd, cmd_exec_allowed, power_off_safe;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_r, d;
  logic [31:0] rnd = 32'h3012;
  logic [7:0] sq_outstanding_r;
  logic [23:0] ns;
  logic [15:0] sav [3];
  int err_count = 0;
  int tests_run = 0;
  int i, j, k, f;
  shutdown_ctrl i_shutdown_ctrl (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .sq_outstanding_r(sq_outstanding_r), .cmd_exec_allowed(cmd_exec_allowed),
    .power_off_safe(power_off_safe));
  host_model i_host_model (.mclk(mclk), .reg_rdata_r(reg_rdata_r), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  // Bench clock
  initial begin
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [15:0] dflt(input int n);
    return 16'(`FEAT_DEFAULTS >> (16 * n));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for ready; the settle time is several cycles
  task wait_ready;
    i = 0;
    while (cmd_exec_allowed !== 1'h1 && i < 60) begin
      @(posedge mclk);
      i++;
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    i_host_model.rd(`REG_CTRL_CFG, d);
    chk(d, 32'h10, "cfg reset");
    i_host_model.rd(`REG_CTRL_STATUS, d);
    chk(d, 32'h0, "status reset");
    i_host_model.rd(4'hF, d);
    chk(d, 32'h0, "unmapped read");
    i_host_model.wr(`REG_CTRL_CFG, 32'h11);
    wait_ready;
    i_host_model.rd(`REG_CTRL_STATUS, d);
    chk(d[0], 1'h1, "ready");
    $display("test enable done");
    for (k = 0; k < 6; k++) begin
      rnd = xs(rnd);
      f = k % 3;
      ns = (f == 1) ? {22'h0, rnd[17:16]} + 24'h1 : (k[0] ? `NSID_ALL_ONES : 24'h0);
      i_host_model.feat(`OP_SET, `SEL_CURRENT, f[1:0], ns, rnd[15:0], d);
      chk({d[31], d[23:16]}, {1'h1, `ST_OK}, "set");
      if (f != 1) sav[f] = rnd[15:0];
      for (j = 0; j < 3; j++) begin
        i_host_model.feat(`OP_GET, j[2:0], f[1:0], ns, 16'h0, d);
        chk(d, {8'h80, `ST_OK, j == 1 ? dflt(f) : rnd[15:0]}, "get");
      end
    end
    for (j = 1; j < 3; j++) begin
      i_host_model.feat(j[1:0], `SEL_CURRENT, 2'h3, 24'h0, 16'h0, d);
      chk(d[23:16], `ST_INVALID_FIELD, "bad id");
    end
    $display("test features done");
    rnd = xs(rnd);
    i_host_model.wr(`REG_SQ_DELETE, {24'h0, rnd[7:0] | 8'h1});
    chk(sq_outstanding_r, rnd[7:0] | 8'h1, "sq load");
    i_host_model.wr(`REG_SQ_DELETE, 32'h8000_0000);
    chk(sq_outstanding_r, 8'h0, "sq abort");
    i_host_model.rd(`REG_SQ_ABORTED, d);
    chk(d, {24'h0, rnd[7:0] | 8'h1}, "aborted count");
    $display("test queue done");
    rnd = xs(rnd);
    i_host_model.event_service(rnd[15:0] & ~rnd[31:16], d);
    chk(d, {8'h80, `ST_OK, 16'h0}, "events masked");
    i_host_model.feat(`OP_GET, `SEL_CURRENT, 2'h0, 24'h0, 16'h0, d);
    chk(d[15:0], rnd[15:0] & ~rnd[31:16], "events re-armed");
    chk(i_host_model.events_out, 32'h1, "event request re-posted");
    $display("test events done");
    for (k = 1; k < 3; k++) begin
      i_host_model.shut(k[1:0]);
      i_host_model.rd(`REG_CTRL_STATUS, d);
      chk(d[3:2], `SHST_BUSY, "busy");
      i_host_model.wait_done(d);
      chk(d[3:2], `SHST_DONE, "done");
      chk(cmd_exec_allowed, 1'h0, "halted");
      i_host_model.feat(`OP_SET, `SEL_CURRENT, 2'h0, 24'h0, 16'h5A5A, d);
      chk(d[31], 1'h0, "command ignored");
      i_host_model.wr(`REG_CTRL_CFG, 32'h10);
      chk(power_off_safe, 1'h1, "safe after clear");
      i_host_model.rd(`REG_CTRL_STATUS, d);
      chk(d, {28'h0, `SHST_DONE, 2'h0}, "done kept");
      i_host_model.wr(`REG_CTRL_CFG, 32'h11);
      wait_ready;
      chk(power_off_safe, 1'h0, "safe dropped");
      i_host_model.feat(`OP_GET, `SEL_CURRENT, 2'h2, 24'h0, 16'h0, d);
      chk(d[15:0], sav[2], "reload");
      $display("test shutdown %0d done", k);
    end
    i_host_model.wr(`REG_CTRL_CFG, 32'h0);
    i_host_model.wr(`REG_CTRL_CFG, 32'h1);
    wait_ready;
    i_host_model.feat(`OP_SET, `SEL_CURRENT, 2'h0, 24'h0, 16'h0C3A, d);
    i_host_model.feat(`OP_SET, `SEL_CURRENT, 2'h0, 24'h2, 16'h1234, d);
    chk(d[23:16], `ST_NOT_NS_SPECIFIC, "not ns specific");
    i_host_model.feat(`OP_GET, `SEL_CURRENT, 2'h0, 24'h2, 16'h0, d);
    chk(d[15:0], 16'h0C3A, "wide value");
    i_host_model.feat(`OP_GET, `SEL_SAVED, 2'h0, 24'h0, 16'h0, d);
    chk(d[15:0], dflt(0), "saved gives default");
    $display("test no save done");
    end_sim;
  end
  // Watchdog; the run needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim;
  end
endmodule
`default_nettype wire
